// ### pkg/trim_pkg.sv
// Functional notes
// - The fourth core's offset register holds a 12-bit trim in bits 11:0 that is applied to core four.
// - The fifth core's offset register holds a 12-bit trim in bits 11:0 that is applied to core five.
// - Cores zero and one each take a 5-bit fine gain trim from bits 4:0 of their own gain register.
// - Core two applies the first input's gain trim on the first input and the second input's trim on the second.
// - Core three applies the third input's 5-bit gain trim whenever it samples the third input.
// - Every trim field takes its default from the factory fuse image, not only from a constant.
// - Each offset trim field is an unsigned binary number.
package trim_pkg;

  // ----------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------
  localparam int unsigned addr_w = 12;
  localparam logic [9:0] idx_core4_offset = 10'h33c;
  localparam logic [9:0] idx_core5_offset = 10'h33e;
  localparam logic [9:0] idx_core0_gain = 10'h360;
  localparam logic [9:0] idx_core1_gain = 10'h361;
  localparam logic [9:0] idx_core2_first_gain = 10'h362;
  localparam logic [9:0] idx_core2_second_gain = 10'h363;
  localparam logic [9:0] idx_core3_third_gain = 10'h364;

  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [15:0] offset_reset = 16'h0000;
  localparam logic [7:0] gain_reset = 8'h00;
  localparam int unsigned offset_msb = 11;
  localparam int unsigned gain_msb = 4;

  typedef enum logic [2:0] {
    sel_core4_offset = 3'h0,
    sel_core5_offset = 3'h1,
    sel_core0_gain = 3'h2,
    sel_core1_gain = 3'h3,
    sel_core2_first = 3'h4,
    sel_core2_second = 3'h5,
    sel_core3_third = 3'h6,
    sel_none = 3'h7
  } reg_sel_t;

  // full register image, reserved bits included
  typedef struct packed {
    logic [15:0] core4_offset_trim;
    logic [15:0] core5_offset_trim;
    logic [7:0] core0_fine_gain_trim;
    logic [7:0] core1_fine_gain_trim;
    logic [7:0] core2_first_input_gain_trim;
    logic [7:0] core2_second_input_gain_trim;
    logic [7:0] core3_third_input_gain_trim;
  } trim_image_t;

  // trims as the converter cores use them
  typedef struct packed {
    logic [11:0] core4_offset;
    logic [11:0] core5_offset;
    logic [4:0] core0_gain;
    logic [4:0] core1_gain;
    logic [4:0] core2_gain;
    logic [4:0] core3_gain;
    logic core3_gain_valid;
  } trim_apply_t;

endpackage

// ### src/adc_core_trim_registers.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
module adc_core_trim_registers (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [trim_pkg::addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fuse_load,
  input wire trim_pkg::trim_image_t fuse_image,
  input wire logic core2_on_second_input,
  input wire logic core3_on_third_input,
  output trim_pkg::trim_apply_t trim_apply
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic trim_pkg::reg_sel_t decode(input logic [trim_pkg::addr_w-1:0] a);
    trim_pkg::reg_sel_t s;
    s = trim_pkg::sel_none;
    if (a[1:0] == 2'h0) begin
      case (a[trim_pkg::addr_w-1:2])
        trim_pkg::idx_core4_offset: s = trim_pkg::sel_core4_offset;
        trim_pkg::idx_core5_offset: s = trim_pkg::sel_core5_offset;
        trim_pkg::idx_core0_gain: s = trim_pkg::sel_core0_gain;
        trim_pkg::idx_core1_gain: s = trim_pkg::sel_core1_gain;
        trim_pkg::idx_core2_first_gain: s = trim_pkg::sel_core2_first;
        trim_pkg::idx_core2_second_gain: s = trim_pkg::sel_core2_second;
        trim_pkg::idx_core3_third_gain: s = trim_pkg::sel_core3_third;
        default: s = trim_pkg::sel_none;
      endcase
    end
    return s;
  endfunction

  trim_pkg::trim_image_t image_r, image_nxt;
  trim_pkg::trim_apply_t apply_r, apply_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  trim_pkg::reg_sel_t sel;
  logic wr_en;
  logic setup;

  assign sel = decode(paddr);
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_r & pwrite;

  // ----------------------------------------
  // register image
  // ----------------------------------------
  always_comb begin
    image_nxt = image_r;
    if (fuse_load) begin
      image_nxt = fuse_image;
    end else if (wr_en) begin
      // reserved bits stored as written; software keeps them zero
      case (sel)
        trim_pkg::sel_core4_offset: image_nxt.core4_offset_trim = pwdata[15:0];
        trim_pkg::sel_core5_offset: image_nxt.core5_offset_trim = pwdata[15:0];
        trim_pkg::sel_core0_gain: image_nxt.core0_fine_gain_trim = pwdata[7:0];
        trim_pkg::sel_core1_gain: image_nxt.core1_fine_gain_trim = pwdata[7:0];
        trim_pkg::sel_core2_first: image_nxt.core2_first_input_gain_trim = pwdata[7:0];
        trim_pkg::sel_core2_second: image_nxt.core2_second_input_gain_trim = pwdata[7:0];
        trim_pkg::sel_core3_third: image_nxt.core3_third_input_gain_trim = pwdata[7:0];
        default: image_nxt = image_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      image_r <= '{trim_pkg::offset_reset, trim_pkg::offset_reset, trim_pkg::gain_reset, trim_pkg::gain_reset,
                   trim_pkg::gain_reset, trim_pkg::gain_reset, trim_pkg::gain_reset};
    end else begin
      image_r <= image_nxt;
    end
  end

  // ----------------------------------------
  // applied trims
  // ----------------------------------------
  always_comb begin
    apply_nxt.core4_offset = image_nxt.core4_offset_trim[trim_pkg::offset_msb:0];
    apply_nxt.core5_offset = image_nxt.core5_offset_trim[trim_pkg::offset_msb:0];
    apply_nxt.core0_gain = image_nxt.core0_fine_gain_trim[trim_pkg::gain_msb:0];
    apply_nxt.core1_gain = image_nxt.core1_fine_gain_trim[trim_pkg::gain_msb:0];
    apply_nxt.core2_gain = core2_on_second_input ?
      image_r.core2_second_input_gain_trim[trim_pkg::gain_msb:0] :
      image_r.core2_first_input_gain_trim[trim_pkg::gain_msb:0];
    // third input gain; other inputs' trims live elsewhere
    apply_nxt.core3_gain = core3_on_third_input ? image_r.core3_third_input_gain_trim[trim_pkg::gain_msb:0] : 5'h00;
    apply_nxt.core3_gain_valid = core3_on_third_input;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      apply_r <= '0;
    end else begin
      apply_r <= apply_nxt;
    end
  end

  // ----------------------------------------
  // apb answer, one access cycle
  // ----------------------------------------
  always_comb begin
    pready_nxt = setup;
    pslverr_nxt = setup & (sel == trim_pkg::sel_none);
    prdata_nxt = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (sel)
        trim_pkg::sel_core4_offset: prdata_nxt = {16'h0000, image_r.core4_offset_trim};
        trim_pkg::sel_core5_offset: prdata_nxt = {16'h0000, image_r.core5_offset_trim};
        trim_pkg::sel_core0_gain: prdata_nxt = {24'h000000, image_r.core0_fine_gain_trim};
        trim_pkg::sel_core1_gain: prdata_nxt = {24'h000000, image_r.core1_fine_gain_trim};
        trim_pkg::sel_core2_first: prdata_nxt = {24'h000000, image_r.core2_first_input_gain_trim};
        trim_pkg::sel_core2_second: prdata_nxt = {24'h000000, image_r.core2_second_input_gain_trim};
        trim_pkg::sel_core3_third: prdata_nxt = {24'h000000, image_r.core3_third_input_gain_trim};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign trim_apply = apply_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_write(trim_pkg::reg_sel_t r);
    psel && penable && pready_r && pwrite && !fuse_load && sel == r;
  endsequence

  sequence s_read(trim_pkg::reg_sel_t r);
    psel && penable && pready_r && !pwrite && sel == r;
  endsequence

  property p_core4_offset;
    s_write(trim_pkg::sel_core4_offset) |=> trim_apply.core4_offset == $past(pwdata[11:0]);
  endproperty
  a_core4_offset: assert property (p_core4_offset) else $error("core four offset not applied");

  property p_core5_offset;
    s_write(trim_pkg::sel_core5_offset) |=> trim_apply.core5_offset == $past(pwdata[11:0]);
  endproperty
  a_core5_offset: assert property (p_core5_offset) else $error("core five offset not applied");

  property p_core0_gain;
    s_write(trim_pkg::sel_core0_gain) |=> trim_apply.core0_gain == $past(pwdata[4:0]) ##1
      trim_apply.core1_gain == $past(trim_apply.core1_gain);
  endproperty
  a_core0_gain: assert property (p_core0_gain) else $error("core zero gain wrong");

  property p_core1_gain;
    s_write(trim_pkg::sel_core1_gain) |=> trim_apply.core1_gain == $past(pwdata[4:0]);
  endproperty
  a_core1_gain: assert property (p_core1_gain) else $error("core one gain wrong");

  property p_core2_select;
    !core2_on_second_input ##1 !core2_on_second_input |->
      trim_apply.core2_gain == $past(image_r.core2_first_input_gain_trim[4:0]);
  endproperty
  a_core2_select: assert property (p_core2_select) else $error("core two gain not from first input");

  property p_core2_second;
    core2_on_second_input |=> trim_apply.core2_gain == $past(image_r.core2_second_input_gain_trim[4:0]);
  endproperty
  a_core2_second: assert property (p_core2_second) else $error("core two gain not from second input");

  property p_core3_third;
    core3_on_third_input |=> trim_apply.core3_gain_valid &&
      trim_apply.core3_gain == $past(image_r.core3_third_input_gain_trim[4:0]);
  endproperty
  a_core3_third: assert property (p_core3_third) else $error("core three third input gain wrong");

  property p_fuse_load;
    fuse_load |=> image_r == $past(fuse_image) ##1 trim_apply.core4_offset == $past(fuse_image.core4_offset_trim[11:0], 2);
  endproperty
  a_fuse_load: assert property (p_fuse_load) else $error("fuse default not loaded");

  property p_offset_unsigned;
    s_read(trim_pkg::sel_core5_offset) |-> prdata[31:16] == 16'h0000 && pslverr == 1'b0;
  endproperty
  a_offset_unsigned: assert property (p_offset_unsigned) else $error("offset read not zero extended");

  property p_readback;
    s_read(trim_pkg::sel_core3_third) |-> prdata[7:0] == $past(image_r.core3_third_input_gain_trim);
  endproperty
  a_readback: assert property (p_readback) else $error("read does not return stored value");

  property p_core4_readback;
    s_read(trim_pkg::sel_core4_offset) |-> prdata[15:0] == $past(image_r.core4_offset_trim);
  endproperty
  a_core4_readback: assert property (p_core4_readback) else $error("offset read not stored value");

endmodule

// ### dv/tb_adc_core_trim_registers.sv
`timescale 1ns/10ps
module tb_adc_core_trim_registers;
  // ----------------------------------------
  // stimulus signals and design
  // ----------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic fuse_load = 1'b0;
  logic core2_on_second_input = 1'b0;
  logic core3_on_third_input = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  trim_pkg::trim_image_t fuse_image = '0;
  trim_pkg::trim_apply_t trim_apply;
  int num_errors = 0;
  int checks_done = 0;
  // register byte addresses, four times the index
  logic [11:0] addr_tab [7] = '{12'hcf0, 12'hcf8, 12'hd80, 12'hd84, 12'hd88, 12'hd8c, 12'hd90};
  logic [31:0] val_tab [7] = '{default: 32'h0};

  adc_core_trim_registers adc_core_trim_registers_i (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fuse_load(fuse_load), .fuse_image(fuse_image),
    .core2_on_second_input(core2_on_second_input), .core3_on_third_input(core3_on_third_input),
    .trim_apply(trim_apply));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // request held until pready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready wait cycles", 32'(n), 32'h1);
  endtask

  task chk_regs();
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, addr_tab[i], 32'h0, rd, err);
      chk("register read", rd, val_tab[i]);
      chk("register error", 32'(err), 32'h0);
    end
  endtask

  // apply path settles within three edges of any change
  task chk_apply();
    repeat (3) @(posedge clk);
    chk("core4 offset", 32'(trim_apply.core4_offset), 32'(val_tab[0][11:0]));
    chk("core5 offset", 32'(trim_apply.core5_offset), 32'(val_tab[1][11:0]));
    chk("core0 gain", 32'(trim_apply.core0_gain), 32'(val_tab[2][4:0]));
    chk("core1 gain", 32'(trim_apply.core1_gain), 32'(val_tab[3][4:0]));
    chk("core2 gain", 32'(trim_apply.core2_gain),
        32'(core2_on_second_input ? val_tab[5][4:0] : val_tab[4][4:0]));
    chk("core3 gain", 32'(trim_apply.core3_gain), 32'(core3_on_third_input ? val_tab[6][4:0] : 5'h0));
    chk("core3 valid", 32'(trim_apply.core3_gain_valid), 32'(core3_on_third_input));
  endtask

  task stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    chk_regs();
    chk_apply();
    $display("test reset values done");
    // reserved bits kept zero; 0xfff is the unsigned top of the offset range
    // no offset calibration runs here, so offsets may be accessed
    val_tab = '{32'h0fff, 32'h0a5c, 32'h1f, 32'h15, 32'h0a, 32'h11, 32'h1e};
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, addr_tab[i], val_tab[i], rd, err);
    end
    chk_regs();
    chk_apply();
    core2_on_second_input <= 1'b1;
    core3_on_third_input <= 1'b1;
    chk_apply();
    $display("test write and input select done");
    apb(1'b1, 12'hcf4, 32'h0777, rd, err);
    chk("unmapped write error", 32'(err), 32'h1);
    apb(1'b0, 12'hcf4, 32'h0, rd, err);
    chk("unmapped read error", 32'(err), 32'h1);
    chk("unmapped read data", rd, 32'h0);
    apb(1'b0, 12'hcf1, 32'h0, rd, err);
    chk("misaligned read error", 32'(err), 32'h1);
    chk_regs();
    $display("test unmapped done");
    val_tab = '{32'h0123, 32'h0456, 32'h07, 32'h08, 32'h09, 32'h0c, 32'h0b};
    @(posedge clk);
    fuse_image <= {val_tab[0][15:0], val_tab[1][15:0], val_tab[2][7:0], val_tab[3][7:0],
                   val_tab[4][7:0], val_tab[5][7:0], val_tab[6][7:0]};
    fuse_load <= 1'b1;
    core3_on_third_input <= 1'b0;
    @(posedge clk);
    fuse_load <= 1'b0;
    chk_apply();
    chk_regs();
    $display("test fuse load done");
    stop_test();
  end

  // about 140 cycles expected; a hang is cut well after that
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("test watchdog expired");
    stop_test();
  end
endmodule
